//--- bit_fifo.sv
// Small first-in first-out buffer held in flip-flops
`timescale 1ns/100ps
`default_nettype none

module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8,
    parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // Fill level
    output logic [CW-1:0] level
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic room;
        logic empty;
    } fifo_s;

    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    fifo_s state_ff;
    fifo_s nxt_state;
    logic push;
    logic pop;

    assign in_ready = state_ff.room;
    assign out_valid = !state_ff.empty;
    assign out_data = state_ff.mem[state_ff.rp];
    assign level = state_ff.cnt;

    always_comb begin
        nxt_state = state_ff;
        push = in_valid && state_ff.room;
        pop = out_ready && !state_ff.empty;
        if (push) begin
            nxt_state.mem[state_ff.wp] = in_data;
            nxt_state.wp = (state_ff.wp == PTR_LAST) ? '0 :
                AW'(state_ff.wp + 1'b1);
        end
        if (pop) begin
            nxt_state.rp = (state_ff.rp == PTR_LAST) ? '0 :
                AW'(state_ff.rp + 1'b1);
        end
        if (push && !pop) begin
            nxt_state.cnt = CW'(state_ff.cnt + 1'b1);
        end else if (pop && !push) begin
            nxt_state.cnt = CW'(state_ff.cnt - 1'b1);
        end
        // Flags are registered so the ready seen outside is a flop
        nxt_state.room = (nxt_state.cnt != CNT_FULL);
        nxt_state.empty = (nxt_state.cnt == '0);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '{mem: '0, wp: '0, rp: '0, cnt: '0,
                room: 1'b1, empty: 1'b1};
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule

`default_nettype wire

//--- infrared_pulse_codec.sv
// Infrared pulse encoder and decoder between serial port and pins
`timescale 1ns/100ps
`default_nettype none
`include "infrared_pulse_codec_params.svh"

module infrared_pulse_codec #(
    parameter int FIFO_WIDTH = 1,
    parameter int FIFO_DEPTH = `IRC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [`IRC_ADDR_W-1:0] reg_addr,
    input wire logic [`IRC_DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`IRC_DATA_W-1:0] reg_rd_data,
    // Baud ticks from the serial port
    input wire logic baud_x16_clock,
    input wire logic baud_x32_clock,
    // Bits from the transmit shift register
    input wire logic tx_bit_valid,
    input wire logic tx_bit_data,
    output logic tx_bit_ready,
    // Bits to the receive shift register
    output logic rx_serial,
    // Infrared pins
    output logic ir_tx_pin,
    input wire logic ir_rx_pin
);

    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ir_en;
        logic invert;
        logic [1:0] width;
        infrared_pulse_codec_pkg::enc_state_e st;
        infrared_pulse_codec_pkg::tick_t tick;
        logic cur_bit;
        logic pulse32;
        logic tx_pin;
        logic [2:0] rx_sync;
        logic rx_level;
        logic rx_pend;
        logic [4:0] stretch;
        logic rx_ser;
        logic [`IRC_DATA_W-1:0] rd_data;
    } codec_s;

    codec_s state_ff;
    codec_s nxt_state;

    logic fifo_valid;
    logic fifo_data;
    logic fifo_pop;
    logic [CW-1:0] fifo_level;
    logic pulse_on;
    logic now_active;
    logic was_active;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic addr_hit(
        input logic [`IRC_ADDR_W-1:0] a,
        input logic [`IRC_ADDR_W-1:0] target
    );
        addr_hit = (a == target);
    endfunction

    // Pulse window inside a 0 bit for the chosen width
    function automatic logic in_window(
        input logic [1:0] wid,
        input infrared_pulse_codec_pkg::tick_t t,
        input logic p32
    );
        case (wid)
            `IRC_WID_1_16: begin
                in_window = (t == `IRC_MID_TICK);
            end
            `IRC_WID_1_32: begin
                in_window = p32;
            end
            default: begin
                // Unused code falls back to the widest pulse
                in_window = (t >= `IRC_WIDE_FIRST) &&
                    (t <= `IRC_WIDE_LAST);
            end
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Transmit buffer
    // ----------------------------------------------------------------
    bit_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .CW(CW)
    ) u_tx_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(tx_bit_valid),
        .in_data(tx_bit_data),
        .in_ready(tx_bit_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop),
        .level(fifo_level)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        fifo_pop = 1'b0;
        pulse_on = 1'b0;
        now_active = 1'b0;
        was_active = 1'b0;

        // Register writes
        if (reg_wr && addr_hit(reg_addr, `IRC_CTRL_ADDR)) begin
            nxt_state.ir_en = reg_wr_data[`IRC_CTRL_EN_BIT];
            nxt_state.invert = reg_wr_data[`IRC_CTRL_INV_BIT];
            nxt_state.width =
                reg_wr_data[`IRC_CTRL_WID_MSB:`IRC_CTRL_WID_LSB];
        end

        // Register reads: data stands one cycle, zero otherwise
        nxt_state.rd_data = '0;
        if (reg_rd) begin
            if (addr_hit(reg_addr, `IRC_CTRL_ADDR)) begin
                nxt_state.rd_data[`IRC_CTRL_EN_BIT] = state_ff.ir_en;
                nxt_state.rd_data[`IRC_CTRL_INV_BIT] = state_ff.invert;
                nxt_state.rd_data[`IRC_CTRL_WID_MSB:`IRC_CTRL_WID_LSB] =
                    state_ff.width;
            end else if (addr_hit(reg_addr, `IRC_STAT_ADDR)) begin
                nxt_state.rd_data[`IRC_STAT_BUSY_BIT] =
                    (state_ff.st == infrared_pulse_codec_pkg::ENC_BIT);
                nxt_state.rd_data[`IRC_STAT_RXLVL_BIT] = state_ff.rx_level;
                nxt_state.rd_data[`IRC_STAT_RXSER_BIT] = state_ff.rx_ser;
                nxt_state.rd_data[`IRC_STAT_CNT_MSB:`IRC_STAT_CNT_LSB] =
                    4'(fifo_level);
            end
        end

        // Encoder: one bit lasts sixteen 16x ticks
        case (state_ff.st)
            infrared_pulse_codec_pkg::ENC_IDLE: begin
                if (fifo_valid) begin
                    fifo_pop = 1'b1;
                    nxt_state.cur_bit = fifo_data;
                    nxt_state.tick = '0;
                    nxt_state.st = infrared_pulse_codec_pkg::ENC_BIT;
                end
            end
            infrared_pulse_codec_pkg::ENC_BIT: begin
                if (baud_x16_clock) begin
                    if (state_ff.tick == `IRC_TICK_LAST) begin
                        // Back to back bits keep the baud grid
                        if (fifo_valid) begin
                            fifo_pop = 1'b1;
                            nxt_state.cur_bit = fifo_data;
                            nxt_state.tick = '0;
                        end else begin
                            nxt_state.st =
                                infrared_pulse_codec_pkg::ENC_IDLE;
                        end
                    end else begin
                        nxt_state.tick =
                            4'(state_ff.tick + 1'b1);
                    end
                end
            end
            default: begin
                nxt_state.st = infrared_pulse_codec_pkg::ENC_IDLE;
            end
        endcase

        // Narrow pulse of one 32x tick from the start of mid-bit
        if (baud_x16_clock && (nxt_state.tick == `IRC_MID_TICK) &&
            (state_ff.tick != `IRC_MID_TICK)) begin
            nxt_state.pulse32 = 1'b1;
        end else if (baud_x32_clock && state_ff.pulse32) begin
            nxt_state.pulse32 = 1'b0;
        end else if (nxt_state.tick != `IRC_MID_TICK) begin
            nxt_state.pulse32 = 1'b0;
        end

        pulse_on = (state_ff.st == infrared_pulse_codec_pkg::ENC_BIT) &&
            !state_ff.cur_bit &&
            in_window(state_ff.width, state_ff.tick,
                state_ff.pulse32);

        if (state_ff.ir_en) begin
            nxt_state.tx_pin = pulse_on ^ state_ff.invert;
        end else if (state_ff.st == infrared_pulse_codec_pkg::ENC_BIT) begin
            nxt_state.tx_pin = state_ff.cur_bit;
        end else begin
            nxt_state.tx_pin = 1'b1;
        end

        // Receive pin: three flops, level moves when last two agree
        nxt_state.rx_sync = {state_ff.rx_sync[1:0], ir_rx_pin};
        if (state_ff.rx_sync[1] == state_ff.rx_sync[2]) begin
            nxt_state.rx_level = state_ff.rx_sync[2];
        end
        was_active = state_ff.rx_level ^ state_ff.invert;
        now_active = nxt_state.rx_level ^ state_ff.invert;

        // Decoder timed only by the 16x tick
        if (baud_x16_clock) begin
            if (state_ff.rx_pend) begin
                nxt_state.stretch = `IRC_STRETCH_TICKS;
                nxt_state.rx_pend = 1'b0;
            end else if (state_ff.stretch != '0) begin
                nxt_state.stretch = 5'(state_ff.stretch - 1'b1);
            end
        end
        // A new pulse edge wins over consuming the old one
        if (now_active && !was_active) begin
            nxt_state.rx_pend = 1'b1;
        end

        if (state_ff.ir_en) begin
            nxt_state.rx_ser = (nxt_state.stretch == '0);
        end else begin
            nxt_state.rx_ser = nxt_state.rx_level;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '{
                ir_en: 1'b0,
                invert: 1'b0,
                width: `IRC_WID_3_16,
                st: infrared_pulse_codec_pkg::ENC_IDLE,
                tick: '0,
                cur_bit: 1'b1,
                pulse32: 1'b0,
                tx_pin: 1'b1,
                rx_sync: '0,
                rx_level: 1'b0,
                rx_pend: 1'b0,
                stretch: '0,
                rx_ser: 1'b1,
                rd_data: '0
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Rates from 2.4 to 115.2 kbit/s only depend on the tick spacing
    assign ir_tx_pin = state_ff.tx_pin;
    assign rx_serial = state_ff.rx_ser;
    assign reg_rd_data = state_ff.rd_data;

endmodule

`default_nettype wire

//--- infrared_pulse_codec_params.svh
// Constants of the infrared pulse codec: offsets, fields, resets, counts
//
// Overview of operation
// - In infrared mode a 0 bit produces one narrow pulse on the transmit pin and a 1 bit leaves it idle.
// - Each pulse sits in the middle of its bit and lasts 1/32, 1/16 or 3/16 of a bit time as selected.
// - The encoder takes its bits from the serial port transmit shift register and drives the transmit pin.
// - The decoder reads the receive pin, turns a pulse into a 0 and no pulse into a 1, and feeds the receiver.
// - One polarity bit inverts both the sent pulses and the expected received pulses.
// - The receive decoder runs only from the 16 times baud tick.
// - Only serial rates from 2.4 kbit/s to 115.2 kbit/s need be supported.
// - With infrared mode off the lines carry plain NRZ data; with it on, 0 bits are pulses and 1 bits stay idle.
`ifndef INFRARED_PULSE_CODEC_PARAMS_SVH
`define INFRARED_PULSE_CODEC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define IRC_ADDR_W 8
`define IRC_DATA_W 8
`define IRC_CTRL_ADDR 8'h00
`define IRC_STAT_ADDR 8'h04

// ----------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------
`define IRC_CTRL_EN_BIT 0
`define IRC_CTRL_INV_BIT 1
`define IRC_CTRL_WID_LSB 2
`define IRC_CTRL_WID_MSB 3
`define IRC_CTRL_RESET 8'h00

// Pulse width codes
`define IRC_WID_3_16 2'h0
`define IRC_WID_1_16 2'h1
`define IRC_WID_1_32 2'h2

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define IRC_STAT_BUSY_BIT 0
`define IRC_STAT_RXLVL_BIT 1
`define IRC_STAT_RXSER_BIT 2
`define IRC_STAT_CNT_LSB 4
`define IRC_STAT_CNT_MSB 7

// ----------------------------------------------------------------
// Timing counts in 16x ticks and transmit buffer depth
// ----------------------------------------------------------------
`define IRC_TICK_LAST 4'hF
`define IRC_MID_TICK 4'h8
`define IRC_WIDE_FIRST 4'h7
`define IRC_WIDE_LAST 4'h9
`define IRC_STRETCH_TICKS 5'h10
`define IRC_FIFO_DEPTH 8

`endif

//--- infrared_pulse_codec_pkg.sv
// Types shared by the infrared pulse codec files
package infrared_pulse_codec_pkg;

    // ----------------------------------------------------------------
    // Encoder states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ENC_IDLE = 2'b01,
        ENC_BIT = 2'b10
    } enc_state_e;

    typedef logic [3:0] tick_t;

endpackage

//--- ir_link_model.sv
// Behavioural infrared transceiver on the pin side of the codec
`timescale 1ns/100ps
`default_nettype none
module ir_link_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bench controls
    input wire logic active_low,
    input wire logic send,
    // Pins
    input wire logic tx_pin,
    output logic rx_pin,
    // What the transmit pin showed
    output logic [7:0] seen_cnt,
    output logic [8:0] seen_wid
);
    logic [8:0] run_ff;
    logic [5:0] left_ff;
    logic act;
    assign act = tx_pin ^ active_low;
    // Line rests at the inactive level between pulses
    assign rx_pin = active_low ^ (left_ff != 6'h00);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_ff <= 9'h000;
            left_ff <= 6'h00;
            seen_cnt <= 8'h00;
            seen_wid <= 9'h000;
        end else begin
            run_ff <= act ? run_ff + 9'h001 : 9'h000;
            if (!act && run_ff != 9'h000) begin
                seen_cnt <= seen_cnt + 8'h01;
                seen_wid <= run_ff;
            end
            // A 0 bit arrives as one pulse of a sixteenth bit
            if (send) begin
                left_ff <= 6'h38;
            end else if (left_ff != 6'h00) begin
                left_ff <= left_ff - 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- irc_checker.sv
// Port checker for the infrared pulse codec
`timescale 1ns/100ps
`default_nettype none
module irc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rd_data,
    // Ticks and pins
    input wire logic baud_x16_clock,
    input wire logic baud_x32_clock,
    input wire logic tx_bit_ready,
    input wire logic rx_serial,
    input wire logic ir_tx_pin,
    input wire logic ir_rx_pin
);
    logic [3:0] ctrl_ff;
    logic [3:0] age_ff;
    logic [2:0] run_ff;
    logic [4:0] low_ff;
    logic act_tx;
    logic act_rx;
    logic ir_q;
    logic nrz_q;
    assign act_tx = ir_tx_pin ^ ctrl_ff[1];
    assign act_rx = ir_rx_pin ^ ctrl_ff[1];
    // Mode checks wait until the control value has settled
    assign ir_q = ctrl_ff[0] && age_ff == 4'hF;
    assign nrz_q = !ctrl_ff[0] && age_ff == 4'hF;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= 4'h0;
            age_ff <= 4'h0;
            run_ff <= 3'h0;
            low_ff <= 5'h00;
        end else begin
            if (reg_wr && reg_addr == 8'h00) begin
                ctrl_ff <= reg_wr_data[3:0];
                age_ff <= 4'h0;
            end else if (age_ff != 4'hF) begin
                age_ff <= age_ff + 4'h1;
            end
            if (!act_tx) begin
                run_ff <= 3'h0;
            end else if (baud_x16_clock) begin
                run_ff <= run_ff + 3'h1;
            end
            if (rx_serial) begin
                low_ff <= 5'h00;
            end else if (baud_x16_clock && low_ff != 5'h1F) begin
                low_ff <= low_ff + 5'h01;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_rx_edge;
        ir_q && $rose(act_rx);
    endsequence
    sequence s_nrz_still;
        (nrz_q && $stable(ir_rx_pin)) [*8];
    endsequence
    a_reset_idle: assert property ($rose(rstn) |->
        ir_tx_pin && rx_serial && tx_bit_ready) else $error("bad idle");
    a_rd_idle_zero: assert property (!$past(reg_rd) |->
        reg_rd_data == 8'h00) else $error("read data outside slot");
    a_ctrl_readback: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h00 |->
        reg_rd_data[3:0] == $past(ctrl_ff)) else $error("ctrl readback");
    a_pulse_start: assert property (
        ir_q && $rose(act_tx) |-> $past(baud_x16_clock, 2))
        else $error("pulse start off tick");
    a_pulse_end: assert property (
        ir_q && $fell(act_tx) |-> $past(baud_x16_clock || baud_x32_clock, 2))
        else $error("pulse end off tick");
    a_pulse_narrow: assert property (ir_q |-> run_ff <= 3'h3)
        else $error("pulse too wide");
    a_rx_answer: assert property (s_rx_edge |-> ##[1:80] !rx_serial)
        else $error("no rx answer");
    a_rx_tick_only: assert property (
        ir_q && $fell(rx_serial) |-> $past(baud_x16_clock))
        else $error("rx fall off tick");
    a_stretch_len: assert property (
        ir_q && $rose(rx_serial) |-> low_ff >= 5'h10)
        else $error("stretch short");
    a_nrz_follow: assert property (s_nrz_still |->
        rx_serial == ir_rx_pin) else $error("nrz rx mismatch");
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the infrared pulse codec
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk, rstn, reg_wr, reg_rd, b16, b32, tick_en;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, seen_cnt;
    logic tx_bit_valid, tx_bit_data, tx_bit_ready, rx_serial;
    logic ir_tx_pin, ir_rx_pin, mdl_al, mdl_send;
    logic [8:0] seen_wid;
    int error_cnt, check_count;
    int tcnt = 0;
    infrared_pulse_codec infrared_pulse_codec_i (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .baud_x16_clock(b16),
        .baud_x32_clock(b32), .tx_bit_valid(tx_bit_valid),
        .tx_bit_data(tx_bit_data), .tx_bit_ready(tx_bit_ready),
        .rx_serial(rx_serial), .ir_tx_pin(ir_tx_pin), .ir_rx_pin(ir_rx_pin));
    ir_link_model ir_link_model_i (.clk(clk), .rstn(rstn),
        .active_low(mdl_al), .send(mdl_send), .tx_pin(ir_tx_pin),
        .rx_pin(ir_rx_pin), .seen_cnt(seen_cnt), .seen_wid(seen_wid));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Ticks at 16x and 32x of 111.6 kbit/s
    always @(posedge clk) begin
        tcnt <= (tcnt == 55) ? 0 : tcnt + 1;
        b16 <= tick_en && tcnt == 0;
        b32 <= tick_en && (tcnt == 0 || tcnt == 28);
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %0h seen %0h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        // Data stand in the cycle after the strobe; take them at its end
        @(posedge clk);
        d = reg_rd_data;
    endtask
    task automatic push(input logic b);
        int n;
        @(posedge clk);
        tx_bit_data <= b;
        tx_bit_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!tx_bit_ready && n < 9000);
        tx_bit_valid <= 1'b0;
        chk("push taken", 1'b1, tx_bit_ready);
    endtask
    task automatic idle();
        logic [7:0] s;
        int n;
        n = 0;
        do begin
            rd(8'h04, s);
            n++;
        end while (!(s[0] === 1'b0 && s[7:4] === 4'h0) && n < 5000);
        chk("drain", 16'h0000, {s[7:4], s[0]});
    endtask
    // Reconfigure, then let any stretch from the switch die away
    // Polarity of the far side only moves while the codec is in NRZ mode
    task automatic cfg(input logic [7:0] c, input logic al,
        output logic [7:0] b);
        int n;
        wr(8'h00, 8'h00);
        mdl_al <= al;
        wr(8'h00, c);
        repeat (100) @(posedge clk);
        n = 0;
        while (rx_serial !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("rx settled", 1'b1, rx_serial);
        repeat (2) @(posedge clk);
        b = seen_cnt;
    endtask
    task automatic t_regs();
        logic [7:0] d;
        rd(8'h00, d);
        chk("ctrl reset", 8'h00, d);
        rd(8'h04, d);
        chk("status reset", 8'h06, d);
        wr(8'h00, 8'h0C);
        rd(8'h00, d);
        chk("ctrl", 8'h0C, d);
        wr(8'h08, 8'h03);
        rd(8'h08, d);
        chk("unmapped", 8'h00, d);
        wr(8'h00, 8'h00);
        $display("regs test done");
    endtask
    task automatic t_nrz();
        push(1'b0);
        push(1'b1);
        push(1'b0);
        repeat (448) @(posedge clk);
        chk("nrz bit0", 1'b0, ir_tx_pin);
        repeat (896) @(posedge clk);
        chk("nrz bit1", 1'b1, ir_tx_pin);
        repeat (896) @(posedge clk);
        chk("nrz bit2", 1'b0, ir_tx_pin);
        idle();
        chk("nrz idle", 1'b1, ir_tx_pin);
        mdl_al <= 1'b0;
        repeat (10) @(posedge clk);
        chk("nrz rx low", 1'b0, rx_serial);
        mdl_al <= 1'b1;
        repeat (10) @(posedge clk);
        chk("nrz rx high", 1'b1, rx_serial);
        $display("nrz test done");
    endtask
    task automatic t_ir_tx(input logic [1:0] w, input logic v,
        input logic [8:0] ew);
        logic [7:0] b;
        cfg({4'h0, w, v, 1'b1}, v, b);
        push(1'b0);
        push(1'b1);
        push(1'b0);
        idle();
        chk("pulse count", 8'h02, seen_cnt - b);
        chk("pulse width", ew, seen_wid);
        chk("idle level", v, ir_tx_pin);
        $display("ir tx test done, width code %0d", w);
    endtask
    task automatic t_fifo();
        logic [7:0] b, s;
        int n;
        cfg(8'h09, 1'b0, b);
        tick_en <= 1'b0;
        tx_bit_data <= 1'b0;
        tx_bit_valid <= 1'b1;
        n = 0;
        repeat (20) begin
            @(posedge clk);
            if (tx_bit_ready === 1'b1) n++;
        end
        tx_bit_valid <= 1'b0;
        chk("accepted", 16'h0009, n);
        chk("ready full", 1'b0, tx_bit_ready);
        rd(8'h04, s);
        chk("status full", 8'h85, s);
        tick_en <= 1'b1;
        idle();
        chk("drained", 8'h09, seen_cnt - b);
        chk("ready empty", 1'b1, tx_bit_ready);
        $display("fifo test done");
    endtask
    task automatic t_rx_ir(input logic v);
        logic [7:0] b;
        int n;
        cfg({6'h00, v, 1'b1}, v, b);
        mdl_send <= 1'b1;
        @(posedge clk);
        mdl_send <= 1'b0;
        n = 0;
        while (rx_serial !== 1'b0 && n < 80) begin
            @(posedge clk);
            n++;
        end
        chk("rx answer", 1'b1, n < 80);
        n = 0;
        while (rx_serial === 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("stretch", 16'h0380, n);
        $display("ir rx test done, invert %0d", v);
    endtask
    initial begin
        {rstn, reg_wr, reg_rd, tx_bit_valid, tx_bit_data} = 5'h00;
        {reg_addr, reg_wr_data, error_cnt, check_count} = 0;
        {tick_en, mdl_al, mdl_send} = 3'b110;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        t_regs();
        t_nrz();
        t_ir_tx(2'h0, 1'b0, 9'h0A8);
        t_ir_tx(2'h1, 1'b1, 9'h038);
        t_ir_tx(2'h2, 1'b0, 9'h01C);
        t_ir_tx(2'h3, 1'b1, 9'h0A8);
        t_fifo();
        t_rx_ir(1'b0);
        t_rx_ir(1'b1);
        conclude();
    end
    initial begin
        #700000;
        error_cnt++;
        conclude();
    end
endmodule
bind infrared_pulse_codec irc_checker irc_checker_i (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .baud_x16_clock(baud_x16_clock), .baud_x32_clock(baud_x32_clock),
    .tx_bit_ready(tx_bit_ready), .rx_serial(rx_serial),
    .ir_tx_pin(ir_tx_pin), .ir_rx_pin(ir_rx_pin));
`default_nettype wire
